// *** tb.sv ***
/* Self-checking bench for ucw_cache against a bus memory model.
 Assumes a 40 MHz clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, rst_b = 1'b0, slow = 1'b0, cfg_wr = 1'b0;
   logic cfg_cache_en = 1'b0, cfg_two_way = 1'b0, rd_req = 1'b0, wr_req = 1'b0;
   logic [19:0] cfg_ncr_base = 20'h0;
   logic [3:0] cfg_ncr_size = 4'h0, wr_be = 4'h0;
   logic [31:0] rd_addr = 32'h0, wr_addr = 32'h0, wr_data = 32'h0;
   wire cache_on, two_way, rd_ready, rd_valid, rd_hit, wr_ready, wb_empty;
   wire bus_req, bus_write, bus_ack;
   wire [31:0] rd_data, bus_addr;
   wire [1:0] bus_be;
   wire [15:0] bus_wdata, bus_rdata;
   int miscompares = 0, n_tests = 0;
   logic [31:0] em [int];
   int eq[$];
   int lru_a[8] = '{'h100, 'h500, 'h100, 'h500, 'h100, 'h900, 'h100, 'h500};
   int lru_h[8] = '{0, 0, 1, 1, 1, 0, 1, 0};
   always #12.5 clk = ~clk;
   ucw_cache dut (
      .clk(clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_cache_en(cfg_cache_en),
      .cfg_two_way(cfg_two_way), .cfg_ncr_base(cfg_ncr_base), .cfg_ncr_size(cfg_ncr_size),
      .cache_on(cache_on), .two_way(two_way), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_data(rd_data),
      .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_be(wr_be),
      .wr_ready(wr_ready), .wb_empty(wb_empty), .bus_req(bus_req), .bus_write(bus_write),
      .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata)
   );
   ucw_mem_model u_mem (
      .clk(clk), .rst_b(rst_b), .slow(slow), .bus_req(bus_req), .bus_write(bus_write),
      .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
      .bus_rdata(bus_rdata)
   );
   task automatic cyc(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] ew(logic [31:0] a);
      int k = a[31:2];
      return em.exists(k) ? em[k] : {{a[16:2], 1'b1} ^ 16'h0f0f, {a[16:2], 1'b0} ^ 16'h0f0f};
   endfunction
   task automatic rd(logic [31:0] a, int hit);
      int t = 0;
      rd_req = 1'b1;
      rd_addr = a;
      // Ready follows the address combinationally, so it is judged on the edge
      @(posedge clk);
      while (rd_ready !== 1'b1 && t++ < 100) @(posedge clk);
      #1;
      rd_req = 1'b0;
      while (rd_valid !== 1'b1 && t++ < 100) cyc();
      chk(rd_data, ew(a));
      if (hit < 2) chk(rd_hit, hit);
      cyc();
   endtask
   // Keep holds the request up so writes can go back to back
   task automatic wr(logic [31:0] a, logic [31:0] d, logic [3:0] be, bit keep);
      int t = 0;
      logic [31:0] w = ew(a);
      wr_req = 1'b1;
      wr_addr = a;
      wr_data = d;
      wr_be = be;
      while (!wr_ready && t++ < 100) cyc();
      cyc();
      for (int i = 0; i < 4; i++) if (be[i]) w[8*i +: 8] = d[8*i +: 8];
      em[a[31:2]] = w;
      if (be[1:0] != 2'h0) eq.push_back({a[31:2], 2'h0});
      if (be[3:2] != 2'h0 || be == 4'h0) eq.push_back({a[31:2], 2'h2});
      if (!keep) begin
         wr_req = 1'b0;
         cyc();
      end
   endtask
   task automatic cfg(logic en, logic tw, logic [3:0] sz);
      cfg_wr = 1'b1;
      cfg_cache_en = en;
      cfg_two_way = tw;
      cfg_ncr_size = sz;
      cyc();
      cfg_wr = 1'b0;
      chk({cache_on, two_way}, {en, tw});
   endtask
   task automatic drain;
      int t = 0;
      while (wb_empty !== 1'b1 && t++ < 300) cyc();
   endtask
   task automatic give_verdict;
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #600000;
      miscompares++;
      give_verdict();
   end
   initial begin
      void'($urandom(25081));
      cyc(12);
      rst_b = 1'b1;
      cyc();
      chk({cache_on, two_way, wr_ready, wb_empty}, 4'h3);
      rd(32'h100, 0);
      cfg(1'b1, 1'b0, 4'hf);
      rd(32'h100, 0);
      rd(32'h100, 0);
      cfg(1'b1, 1'b0, 4'h0);
      rd(32'h100, 0);
      rd(32'h100, 1);
      rd(32'h500, 0);
      rd(32'h100, 0);
      wr(32'h200, 32'h11223344, 4'hf, 0);
      rd(32'h200, 0);
      wr(32'h100, 32'haabbccdd, 4'h5, 0);
      rd(32'h100, 1);
      cfg(1'b1, 1'b1, 4'h0);
      for (int i = 0; i < 8; i++) rd(lru_a[i], lru_h[i]);
      slow = 1'b1;
      wr(32'h600, $urandom, 4'hf, 1);
      wr(32'h604, $urandom, 4'h3, 1);
      chk(wr_ready, 1'b0);
      wr(32'h608, $urandom, 4'h8, 0);
      rd(32'h608, 2);
      for (int i = 0; i < 80; i++) begin
         slow = 1'($urandom);
         if (1'($urandom)) wr({21'h0, 9'($urandom), 2'h0}, $urandom, 4'($urandom), 0);
         else rd({21'h0, 9'($urandom), 2'h0}, 2);
      end
      drain();
      cfg_ncr_base = 20'h00001;
      cfg(1'b1, 1'b0, 4'h1);
      rd(32'h100, 0);
      rd(32'h100, 1);
      rd(32'h1100, 0);
      rd(32'h1100, 0);
      rst_b = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      cyc();
      chk({cache_on, two_way}, 2'h0);
      rd(32'h100, 0);
      chk(u_mem.wq.size(), eq.size());
      foreach (eq[i]) chk(u_mem.wq[i], eq[i]);
      give_verdict();
   end
endmodule // tb

// *** ucw_cache.v ***
/*
 Unified write-through instruction/data cache with a two-entry posted
 write buffer, between the pipeline read/write ports and a 16-bit bus.
 Assumes the bus interface and pipeline run on clk, so no synchronisers.
*/
`timescale 1ns/1ps
`include "ucw_map.vh"

// Operation
// - One 1 KByte cache for code and data; every write also reaches memory.
// - Lines are allocated on read misses only, never on write misses.
// - Direct-mapped mode uses 256 lines of four bytes.
// - Two-way mode uses two ways of 128 lines, LRU replacement.
// - Cache delivers 32 bits per access; the bus moves 16 bits per access.
// - Each bus access lasts at least two clock cycles.
// - Read hits are answered without using the bus.
// - A 32-bit write reaches the cache in a single cycle.
// - Every write is posted through a two-entry write buffer.
// - The pipeline stalls on writes only when the buffer is full.
// - Reset invalidates all lines and leaves the cache disabled.
// - After reset region one covers all 4 GByte, so nothing is cached.
module ucw_cache (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Configuration strobe and state
   input wire cfg_wr,
   input wire cfg_cache_en,
   input wire cfg_two_way,
   input wire [19:0] cfg_ncr_base,
   input wire [3:0] cfg_ncr_size,
   output reg cache_on,
   output reg two_way,
   // Pipeline read port
   input wire rd_req,
   input wire [31:0] rd_addr,
   output wire rd_ready,
   output reg rd_valid,
   output reg rd_hit,
   output reg [31:0] rd_data,
   // Pipeline write port
   input wire wr_req,
   input wire [31:0] wr_addr,
   input wire [31:0] wr_data,
   input wire [3:0] wr_be,
   output wire wr_ready,
   output wire wb_empty,
   // System bus, 16 bits
   output reg bus_req,
   output reg bus_write,
   output reg [31:0] bus_addr,
   output reg [1:0] bus_be,
   output reg [15:0] bus_wdata,
   input wire bus_ack,
   input wire [15:0] bus_rdata
);

   localparam B_IDLE = 2'h0;
   localparam B_LO = 2'h1;
   localparam B_HI = 2'h2;

   // Cache storage
   reg [31:0] c_data [0:`UCW_LINES-1];
   reg [`UCW_TAG_W-1:0] c_tag [0:`UCW_LINES-1];
   reg [`UCW_LINES-1:0] c_vld;
   reg [`UCW_SETS2-1:0] c_lru;

   // Non-cacheable region one
   reg [19:0] ncr_base;
   reg [3:0] ncr_size;

   // Posted write buffer
   reg [31:0] wb_addr [0:1];
   reg [31:0] wb_data [0:1];
   reg [3:0] wb_be [0:1];
   reg [1:0] wb_vld;
   reg wb_head;
   reg wb_tail;

   // Bus sequencer
   reg [1:0] bus_st;
   reg bus_rd;
   reg [1:0] bus_cnt;
   reg [15:0] lo_half;
   reg [31:0] rd_lat;
   reg fill_cab;
   reg fill_kill;

   integer i;

   function ucw_in_ncr;
      input [31:0] a;
      input [19:0] b;
      input [3:0] s;
      reg [31:0] lo;
      begin
         lo = (32'h1 << (s + `UCW_NCR_SHIFT)) - 32'h1;
         if (s == `UCW_NCR_SIZE_OFF)
            ucw_in_ncr = 1'b0;
         else if (s == `UCW_NCR_SIZE_ALL)
            ucw_in_ncr = 1'b1;
         else
            ucw_in_ncr = (((a ^ {b, 12'h000}) & ~lo) == 32'h0);
      end
   endfunction

   // Read lookup; the way bit is the top of the line index
   wire [7:0] r_ln0 = two_way ? {1'b0, rd_addr[8:2]} : rd_addr[9:2];
   wire [7:0] r_ln1 = {1'b1, rd_addr[8:2]};
   wire r_h0 = c_vld[r_ln0] && (c_tag[r_ln0] == rd_addr[31:9]);
   wire r_h1 = two_way && c_vld[r_ln1] && (c_tag[r_ln1] == rd_addr[31:9]);
   wire r_cab = cache_on && !ucw_in_ncr(rd_addr, ncr_base, ncr_size);
   wire r_hit = r_cab && (r_h0 || r_h1);
   wire [7:0] r_line = r_h1 ? r_ln1 : r_ln0;

   // Write lookup
   wire [7:0] w_ln0 = two_way ? {1'b0, wr_addr[8:2]} : wr_addr[9:2];
   wire [7:0] w_ln1 = {1'b1, wr_addr[8:2]};
   wire w_h0 = c_vld[w_ln0] && (c_tag[w_ln0] == wr_addr[31:9]);
   wire w_h1 = two_way && c_vld[w_ln1] && (c_tag[w_ln1] == wr_addr[31:9]);
   wire w_cab = cache_on && !ucw_in_ncr(wr_addr, ncr_base, ncr_size);
   wire w_hit = w_cab && (w_h0 || w_h1);
   wire [7:0] w_line = w_h1 ? w_ln1 : w_ln0;

   // Fill victim: LRU bit names the way to replace next
   wire [7:0] f_line = two_way ? {c_lru[rd_lat[8:2]], rd_lat[8:2]} : rd_lat[9:2];

   // Buffer state
   wire wb_full = &wb_vld;
   assign wb_empty = ~|wb_vld;
   wire wb_match = (wb_vld[0] && (wb_addr[0][31:2] == rd_addr[31:2])) ||
                   (wb_vld[1] && (wb_addr[1][31:2] == rd_addr[31:2]));
   wire [31:0] h_addr = wb_addr[wb_head];
   wire [31:0] h_data = wb_data[wb_head];
   wire [3:0] h_be = wb_be[wb_head];

   // Handshakes
   wire rd_busy = (bus_st != B_IDLE) && bus_rd;
   // Misses wait for an empty buffer so the bus sees writes first
   assign rd_ready = !rd_busy && !wb_match &&
                     (r_hit || (wb_empty && (bus_st == B_IDLE)));
   assign wr_ready = !wb_full;
   wire rd_take = rd_req && rd_ready;
   wire rd_miss = rd_take && !r_hit;
   wire wr_take = wr_req && wr_ready;
   wire bus_done = bus_req && bus_ack && (bus_cnt >= `UCW_BUS_ACK_MIN);

   always @(posedge clk) begin
      if (!rst_b) begin
         cache_on <= `UCW_CACHE_EN_RST;
         two_way <= `UCW_TWO_WAY_RST;
         ncr_base <= `UCW_NCR_BASE_RST;
         ncr_size <= `UCW_NCR_SIZE_RST;
         c_vld <= {`UCW_LINES{1'b0}};
         c_lru <= {`UCW_SETS2{1'b0}};
         wb_vld <= 2'h0;
         wb_head <= 1'b0;
         wb_tail <= 1'b0;
         bus_st <= B_IDLE;
         bus_rd <= 1'b0;
         bus_cnt <= 2'h0;
         bus_req <= 1'b0;
         bus_write <= 1'b0;
         bus_addr <= 32'h0;
         bus_be <= 2'h0;
         bus_wdata <= 16'h0;
         lo_half <= 16'h0;
         rd_lat <= 32'h0;
         fill_cab <= 1'b0;
         fill_kill <= 1'b0;
         rd_valid <= 1'b0;
         rd_hit <= 1'b0;
         rd_data <= 32'h0;
      end else begin
         rd_valid <= 1'b0;
         rd_hit <= 1'b0;
         if (bus_cnt != 2'h3)
            bus_cnt <= bus_cnt + 2'h1;

         // Read hit: answered next cycle from the cache, bus untouched
         if (rd_take && r_hit) begin
            rd_valid <= 1'b1;
            rd_hit <= 1'b1;
            rd_data <= c_data[r_line];
            if (two_way)
               c_lru[r_line[6:0]] <= ~r_line[7];
         end

         // Write: post to the buffer, update a hitting line, never allocate
         if (wr_take) begin
            wb_addr[wb_tail] <= wr_addr;
            wb_data[wb_tail] <= wr_data;
            wb_be[wb_tail] <= wr_be;
            wb_vld[wb_tail] <= 1'b1;
            wb_tail <= ~wb_tail;
            if (w_hit) begin
               for (i = 0; i < 4; i = i + 1) begin
                  if (wr_be[i])
                     c_data[w_line][8*i +: 8] <= wr_data[8*i +: 8];
               end
               if (two_way)
                  c_lru[w_line[6:0]] <= ~w_line[7];
            end
            // A fill in flight would carry stale data for this word
            if ((rd_busy && (rd_lat[31:2] == wr_addr[31:2])) ||
                (rd_miss && (rd_addr[31:2] == wr_addr[31:2])))
               fill_kill <= 1'b1;
         end

         case (bus_st)
            B_IDLE: begin
               if (rd_miss) begin
                  bus_rd <= 1'b1;
                  rd_lat <= rd_addr;
                  fill_cab <= r_cab;
                  fill_kill <= wr_take && (rd_addr[31:2] == wr_addr[31:2]);
                  bus_st <= B_LO;
                  bus_req <= 1'b1;
                  bus_write <= 1'b0;
                  bus_addr <= {rd_addr[31:2], 2'h0};
                  bus_be <= 2'h3;
                  bus_cnt <= 2'h0;
               end else if (!wb_empty) begin
                  // Oldest entry first
                  bus_rd <= 1'b0;
                  bus_req <= 1'b1;
                  bus_write <= 1'b1;
                  bus_cnt <= 2'h0;
                  if (h_be[1:0] != 2'h0) begin
                     bus_st <= B_LO;
                     bus_addr <= {h_addr[31:2], 2'h0};
                     bus_be <= h_be[1:0];
                     bus_wdata <= h_data[15:0];
                  end else begin
                     bus_st <= B_HI;
                     bus_addr <= {h_addr[31:2], 2'h2};
                     bus_be <= h_be[3:2];
                     bus_wdata <= h_data[31:16];
                  end
               end
            end
            B_LO: begin
               if (bus_done) begin
                  if (bus_rd)
                     lo_half <= bus_rdata;
                  if (bus_rd || (h_be[3:2] != 2'h0)) begin
                     bus_st <= B_HI;
                     bus_addr[1] <= 1'b1;
                     bus_be <= bus_rd ? 2'h3 : h_be[3:2];
                     bus_wdata <= h_data[31:16];
                     bus_cnt <= 2'h0;
                  end else begin
                     bus_st <= B_IDLE;
                     bus_req <= 1'b0;
                     wb_vld[wb_head] <= 1'b0;
                     wb_head <= ~wb_head;
                  end
               end
            end
            B_HI: begin
               if (bus_done) begin
                  bus_st <= B_IDLE;
                  bus_req <= 1'b0;
                  if (bus_rd) begin
                     rd_valid <= 1'b1;
                     rd_data <= {bus_rdata, lo_half};
                     // Allocation happens here only, on a cacheable read miss
                     if (fill_cab && !fill_kill && !cfg_wr) begin
                        c_vld[f_line] <= 1'b1;
                        c_tag[f_line] <= rd_lat[31:9];
                        c_data[f_line] <= {bus_rdata, lo_half};
                        if (two_way)
                           c_lru[f_line[6:0]] <= ~f_line[7];
                     end
                  end else begin
                     wb_vld[wb_head] <= 1'b0;
                     wb_head <= ~wb_head;
                  end
               end
            end
            default: begin
               bus_st <= B_IDLE;
               bus_req <= 1'b0;
            end
         endcase

         // Changing organisation or regions makes every tag suspect
         if (cfg_wr) begin
            cache_on <= cfg_cache_en;
            two_way <= cfg_two_way;
            ncr_base <= cfg_ncr_base;
            ncr_size <= cfg_ncr_size;
            c_vld <= {`UCW_LINES{1'b0}};
            fill_kill <= 1'b1;
         end
      end
   end

endmodule // ucw_cache

// *** ucw_cache_properties.sv ***
/* Checker of ucw_cache read, write-buffer and bus timing.
 Assumes binding to ucw_cache on its one clock domain. */
`timescale 1ns/1ps
module ucw_chk (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Pipeline side
   input wire cfg_wr,
   input wire rd_req,
   input wire rd_ready,
   input wire rd_valid,
   input wire rd_hit,
   input wire wr_req,
   input wire wr_ready,
   input wire wb_empty,
   // Bus side
   input wire bus_req,
   input wire bus_write,
   input wire [31:0] bus_addr,
   input wire bus_ack
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   a_hit_next: assert property (rd_hit |-> rd_valid && $past(rd_req && rd_ready))
      else $error("hit timing");
   a_miss_ack: assert property (rd_valid && !rd_hit |-> $past(bus_req && bus_ack))
      else $error("miss without bus");
   a_half_min: assert property ($rose(bus_req) |=> bus_req && $stable(bus_addr))
      else $error("short bus half");
   a_rd_lo_first: assert property ($rose(bus_req) && !bus_write |-> !bus_addr[1])
      else $error("read half order");
   a_rd_after_wr: assert property ($rose(bus_req) && !bus_write |-> $past(wb_empty))
      else $error("read passed write");
   a_no_stall: assert property (wb_empty |-> wr_ready)
      else $error("stall with room");
   a_two_deep: assert property (wr_req && wr_ready && wb_empty |=> wr_ready)
      else $error("buffer not two deep");
   a_cfg_flush: assert property (cfg_wr ##1 (rd_req && rd_ready) |=> !rd_hit)
      else $error("hit after flush");
endmodule // ucw_chk
bind ucw_cache ucw_chk u_chk (
   .clk(clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .rd_req(rd_req), .rd_ready(rd_ready),
   .rd_valid(rd_valid), .rd_hit(rd_hit), .wr_req(wr_req), .wr_ready(wr_ready),
   .wb_empty(wb_empty), .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
   .bus_ack(bus_ack)
);

// *** ucw_map.vh ***
/*
 Constants for the unified cache and posted-write buffer: geometry,
 reset values of the configuration state and bus timing counts.
 Assumes inclusion by ucw_cache.v only; definitions only.
*/
`ifndef UCW_MAP_VH
`define UCW_MAP_VH

// Geometry: 1 KByte as 256 four-byte lines, or two ways of 128
`define UCW_LINES 256
`define UCW_SETS2 128
`define UCW_TAG_W 23

// Reset values of the configuration state
`define UCW_CACHE_EN_RST 1'b0
`define UCW_TWO_WAY_RST 1'b0
`define UCW_NCR_BASE_RST 20'h00000
`define UCW_NCR_SIZE_RST 4'hf

// Region size codes: off, whole 4 GByte space, and shift for the rest
`define UCW_NCR_SIZE_OFF 4'h0
`define UCW_NCR_SIZE_ALL 4'hf
`define UCW_NCR_SHIFT 5'd11

// Earliest counted cycle at which a bus acknowledge ends a half
`define UCW_BUS_ACK_MIN 2'h1

`endif

// *** ucw_mem_model.sv ***
/* Behavioural 16-bit memory answering the cache bus.
 Assumes the bus runs on clk; slow adds wait cycles. */
`timescale 1ns/1ps
module ucw_mem_model (
   // Clock, reset and pacing
   input wire clk,
   input wire rst_b,
   input wire slow,
   // Bus from the cache
   input wire bus_req,
   input wire bus_write,
   input wire [31:0] bus_addr,
   input wire [1:0] bus_be,
   input wire [15:0] bus_wdata,
   output reg bus_ack,
   output reg [15:0] bus_rdata
);
   logic [15:0] mem [int];
   logic [15:0] w;
   int wq[$];
   int cnt;
   int k;
   function automatic logic [15:0] word(int a);
      return mem.exists(a) ? mem[a] : a[15:0] ^ 16'h0f0f;
   endfunction
   // Idle data is inverted each cycle so a stale sample never matches
   always @(posedge clk) begin
      k = bus_addr[31:1];
      if (!rst_b || !bus_req || bus_ack) begin
         cnt <= 0;
         bus_ack <= 1'b0;
         bus_rdata <= rst_b ? ~bus_rdata : 16'h5a5a;
         if (rst_b && bus_req && bus_write) begin
            w = word(k);
            if (bus_be[0]) w[7:0] = bus_wdata[7:0];
            if (bus_be[1]) w[15:8] = bus_wdata[15:8];
            mem[k] = w;
            wq.push_back(bus_addr);
         end
      end else begin
         cnt <= cnt + 1;
         bus_ack <= cnt + 1 >= (slow ? 3 : 1);
         bus_rdata <= (cnt + 1 >= (slow ? 3 : 1)) ? word(k) : ~bus_rdata;
      end
   end
endmodule // ucw_mem_model
